// file: logic/sram_host.v
// Host controller driving a 1K x 4 asynchronous memory with clear
// Functional notes
// - Write starts with select and strobe low, ends when either rises.
// - Address valid, strobe high, select low by clear falling edge.
// - Strobe stays high 30/40 ns after clear rises.
// - Address stays stable 30/40 ns after clear rises.
// - Address valid 20/30 ns before write end.
// - Write data held 5 ns after the ending strobe rises.
// - Write data valid 15/20 ns before write end.
`timescale 1ns/1ps
`include "sram_host_map.vh"
module sram_host #(
    parameter AW = `ADDR_W,
    parameter DW = `DATA_W
) (
    // Clock and reset
    input wire MCLK,
    input wire RST,
    // User request
    input wire REQ_VALID,
    input wire [1:0] REQ_OP,
    input wire [AW-1:0] REQ_ADDR,
    input wire [DW-1:0] REQ_WDATA,
    output reg REQ_READY,
    output reg RSP_VALID,
    output reg [DW-1:0] RSP_RDATA,
    // Memory pins
    output reg [AW-1:0] MEM_ADDR,
    output reg [DW-1:0] WRITE_VALUE_BUS,
    input wire [DW-1:0] READ_VALUE_BUS,
    output reg CS_N,
    output reg WE_N,
    output reg OE_N,
    output reg CLR_N
);
    localparam OP_READ = 2'h0;
    localparam OP_WRITE = 2'h1;
    localparam OP_CLEAR = 2'h2;
    // Counts worked out as integers, then cut to the timer width on purpose;
    // at this clock every count stays far below the four-bit limit
    localparam integer SA_I = `CYC_MIN(`T_SA_NS);
    localparam integer AW_I = `CYC_MIN(`T_AW_NS);
    localparam integer SD_I = `CYC_MIN(`T_SD_NS);
    localparam integer PWE_I = `CYC_MIN(`T_PWE_NS);
    localparam integer HD_I = `CYC_MIN(`T_HD_NS);
    localparam integer HA_I = `CYC_MIN(`T_HA_NS);
    // Wait for access plus two synchroniser stages before sampling
    localparam integer AA_I = `CYC_MIN(`T_AA_NS) + 2;
    localparam integer PR_I = `CYC_MIN(`T_PR_NS);
    localparam integer HWER_I = `CYC_MIN(`T_HWER_NS);
    localparam integer HAR_I = `CYC_MIN(`T_HAR_NS);
    localparam [3:0] C_SA = SA_I[3:0];
    localparam [3:0] C_AW = AW_I[3:0];
    localparam [3:0] C_SD = SD_I[3:0];
    localparam [3:0] C_PWE = PWE_I[3:0];
    localparam [3:0] C_WPULSE = (C_AW > C_SD) ?
        ((C_AW > C_PWE) ? C_AW : C_PWE) : ((C_SD > C_PWE) ? C_SD : C_PWE);
    localparam [3:0] C_HD = HD_I[3:0];
    localparam [3:0] C_HA = HA_I[3:0];
    localparam [3:0] C_WHOLD = (C_HD > C_HA) ? C_HD : C_HA;
    localparam [3:0] C_AA = AA_I[3:0];
    localparam [3:0] C_PR = PR_I[3:0];
    localparam [3:0] C_RHOLD = (HWER_I > HAR_I) ? HWER_I[3:0] : HAR_I[3:0];
    localparam S_IDLE = 3'h0;
    localparam S_SETUP = 3'h1;
    localparam S_WPULSE = 3'h2;
    localparam S_WHOLD = 3'h3;
    localparam S_READ = 3'h4;
    localparam S_CPULSE = 3'h5;
    localparam S_CHOLD = 3'h6;
    localparam S_END = 3'h7;
    reg [2:0] state_q;
    reg [1:0] op_q;
    reg [DW-1:0] rd_meta_q;
    reg [DW-1:0] rd_sync_q;
    reg load;
    reg [3:0] load_cnt;
    wire done;
    step_timer #(.W(4)) u_timer (
        .clk(MCLK),
        .rst(RST),
        .load(load),
        .count(load_cnt),
        .done(done)
    );
    // Read data crosses from the pins through two flops
    always @(posedge MCLK) begin
        rd_meta_q <= READ_VALUE_BUS;
        rd_sync_q <= rd_meta_q;
    end
    always @* begin
        load = 1'b0;
        load_cnt = 4'h0;
        case (state_q)
            S_IDLE: begin
                if (REQ_VALID && REQ_READY) begin
                    load = 1'b1;
                    load_cnt = C_SA;
                end
            end
            S_SETUP: begin
                if (done) begin
                    load = 1'b1;
                    if (op_q == OP_WRITE)
                        load_cnt = C_WPULSE;
                    else if (op_q == OP_CLEAR)
                        load_cnt = C_PR;
                    else
                        load_cnt = C_AA;
                end
            end
            S_WPULSE: begin
                if (done) begin
                    load = 1'b1;
                    load_cnt = C_WHOLD;
                end
            end
            S_CPULSE: begin
                if (done) begin
                    load = 1'b1;
                    load_cnt = C_RHOLD;
                end
            end
            default: begin
                load = 1'b0;
            end
        endcase
    end
    always @(posedge MCLK) begin
        if (RST) begin
            state_q <= S_IDLE;
            op_q <= OP_READ;
            REQ_READY <= 1'b0;
            RSP_VALID <= 1'b0;
            RSP_RDATA <= {DW{1'b0}};
            MEM_ADDR <= {AW{1'b0}};
            WRITE_VALUE_BUS <= {DW{1'b0}};
            CS_N <= 1'b1;
            WE_N <= 1'b1;
            OE_N <= 1'b1;
            CLR_N <= 1'b1;
        end else begin
            RSP_VALID <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    REQ_READY <= 1'b1;
                    if (REQ_VALID && REQ_READY) begin
                        REQ_READY <= 1'b0;
                        op_q <= (REQ_OP == OP_WRITE) ? OP_WRITE :
                            (REQ_OP == OP_CLEAR) ? OP_CLEAR : OP_READ;
                        // Address and data launched before any strobe
                        MEM_ADDR <= REQ_ADDR;
                        WRITE_VALUE_BUS <= REQ_WDATA;
                        CS_N <= 1'b0;
                        WE_N <= 1'b1;
                        OE_N <= 1'b1;
                        state_q <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    if (done) begin
                        if (op_q == OP_WRITE) begin
                            WE_N <= 1'b0;
                            state_q <= S_WPULSE;
                        end else if (op_q == OP_CLEAR) begin
                            CLR_N <= 1'b0;
                            state_q <= S_CPULSE;
                        end else begin
                            OE_N <= 1'b0;
                            state_q <= S_READ;
                        end
                    end
                end
                S_WPULSE: begin
                    // Only the strobe ends the write; select stays low
                    if (done) begin
                        WE_N <= 1'b1;
                        state_q <= S_WHOLD;
                    end
                end
                S_WHOLD: begin
                    // Data and address held past the strobe edge
                    if (done) begin
                        state_q <= S_END;
                    end
                end
                S_READ: begin
                    // Wait covers access time and the sync stages
                    if (done) begin
                        RSP_RDATA <= rd_sync_q;
                        RSP_VALID <= 1'b1;
                        state_q <= S_END;
                    end
                end
                S_CPULSE: begin
                    if (done) begin
                        CLR_N <= 1'b1;
                        state_q <= S_CHOLD;
                    end
                end
                S_CHOLD: begin
                    // Strobe and address unchanged through the hold
                    if (done) begin
                        if (op_q == OP_CLEAR) begin
                            RSP_VALID <= 1'b1;
                        end
                        state_q <= S_END;
                    end
                end
                S_END: begin
                    // Deselect with strobe already high, no output glitch
                    CS_N <= 1'b1;
                    OE_N <= 1'b1;
                    state_q <= S_IDLE;
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule // sram_host

// file: logic/sram_host_map.vh
// Timing constants and widths for the 1K x 4 static memory host controller
`ifndef SRAM_HOST_MAP_VH
`define SRAM_HOST_MAP_VH
`define CLK_PERIOD_NS 100
`define ADDR_W 10
`define DATA_W 4
`define DEPTH 1024
// Host-side minimum times, slower grade, in ns
`define T_AW_NS 30
`define T_SD_NS 20
`define T_HD_NS 5
`define T_HA_NS 5
`define T_SA_NS 5
`define T_PWE_NS 20
`define T_PR_NS 30
`define T_HWER_NS 40
`define T_HAR_NS 40
// Read access limits (longest), in ns
`define T_AA_NS 35
`define T_HZR_NS 25
// Cycles: least times round up, never below one
`define CYC_UP(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_MIN(t) ((`CYC_UP(t) < 1) ? 1 : `CYC_UP(t))
`endif

// file: logic/step_timer.v
// Down-counter that times one phase of a memory cycle
`timescale 1ns/1ps
module step_timer #(
    parameter W = 4
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Load and status
    input wire load,
    input wire [W-1:0] count,
    output reg done
);
    reg [W-1:0] cnt_q;
    always @(posedge clk) begin
        if (rst) begin
            cnt_q <= {W{1'b0}};
            done <= 1'b1;
        end else if (load) begin
            cnt_q <= count;
            done <= (count == {W{1'b0}});
        end else if (cnt_q != {W{1'b0}}) begin
            cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
            done <= (cnt_q == {{(W-1){1'b0}}, 1'b1});
        end
    end
endmodule // step_timer

// file: test/sram_dev_model.sv
// Behavioural 1K x 4 static memory with clear, seen from its pins
`timescale 1ns/1ps
module sram_dev_model (
    // Pins
    input wire [9:0] a,
    input wire [3:0] d,
    output wire [3:0] q,
    input wire cs_n,
    input wire we_n,
    input wire oe_n,
    input wire clr_n
);
    reg [3:0] mem_q [0:1023];
    reg [3:0] last_q = 4'h0;
    integer i;
    wire drv = !cs_n && !oe_n && we_n && clr_n;
    always @(cs_n or we_n or a or d) begin
        if (!cs_n && !we_n) begin
            mem_q[a] = d;
        end
    end
    always @(negedge clr_n) begin
        if (!cs_n && we_n) begin
            for (i = 0; i < 1024; i = i + 1) begin
                mem_q[i] = 4'h0;
            end
        end
    end
    // Floating outputs show the inverted last word, so no stale match
    always @(negedge drv) begin
        last_q = mem_q[a];
    end
    assign q = drv ? mem_q[a] : ~last_q;
endmodule // sram_dev_model

// file: test/sram_host_chk.sv
// Pin sequencing checks on the static memory host controller
`timescale 1ns/1ps
module sram_host_chk #(
    parameter AW = 10,
    parameter DW = 4
) (
    // Clock and reset
    input wire MCLK,
    input wire RST,
    // Watched outputs
    input wire [AW-1:0] MEM_ADDR,
    input wire [DW-1:0] WRITE_VALUE_BUS,
    input wire CS_N,
    input wire WE_N,
    input wire OE_N,
    input wire CLR_N
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);
    AST_WE_NEEDS_CS: assert property (
        !WE_N |-> !CS_N && CLR_N && OE_N)
        else $error("write strobe low outside a plain write");
    AST_CLR_SETUP: assert property (
        $fell(CLR_N) |-> !CS_N && WE_N && $stable(MEM_ADDR))
        else $error("clear started without setup");
    AST_CLR_WE_HOLD: assert property (
        $rose(CLR_N) |-> WE_N ##1 WE_N)
        else $error("write strobe fell too soon after clear");
    AST_CLR_ADDR_HOLD: assert property (
        $rose(CLR_N) |-> $stable(MEM_ADDR) ##1 $stable(MEM_ADDR))
        else $error("address moved too soon after clear");
    AST_WR_ADDR_SETUP: assert property (
        $rose(WE_N) |-> !CS_N && $stable(MEM_ADDR))
        else $error("address not settled before write end");
    AST_WR_DATA_HOLD: assert property (
        $rose(WE_N) |=> $stable(WRITE_VALUE_BUS))
        else $error("write data changed at write end");
    AST_WR_DATA_SETUP: assert property (
        $rose(WE_N) |-> $stable(WRITE_VALUE_BUS))
        else $error("write data not settled before write end");
    AST_READ_SELECTED: assert property (
        !OE_N |-> !CS_N && WE_N && CLR_N)
        else $error("output enable low outside a read");
    cover property ($rose(WE_N));
    cover property ($rose(CLR_N));
    cover property ($fell(OE_N));
endmodule // sram_host_chk
bind sram_host sram_host_chk #(.AW(AW), .DW(DW)) sram_host_chk_inst (
    .MCLK(MCLK), .RST(RST), .MEM_ADDR(MEM_ADDR),
    .WRITE_VALUE_BUS(WRITE_VALUE_BUS), .CS_N(CS_N), .WE_N(WE_N),
    .OE_N(OE_N), .CLR_N(CLR_N));

// file: test/tb_sram_host.sv
// Self-checking bench for the static memory host controller
`timescale 1ns/1ps
module tb_sram_host;
    reg mclk = 1'b0;
    reg rst = 1'b1;
    reg req_valid = 1'b0;
    reg [1:0] req_op = 2'h0;
    reg [9:0] req_addr = 10'h000;
    reg [3:0] req_wdata = 4'h0;
    wire req_ready, rsp_valid, cs_n, we_n, oe_n, clr_n;
    wire [3:0] rsp_rdata, wr_bus, rd_bus;
    wire [9:0] mem_addr;
    integer err_total = 0;
    integer compares = 0;
    int ref_mem [1024];
    int addr_q [$];
    logic [3:0] got;
    logic [9:0] a;
    sram_host sram_host_inst (.MCLK(mclk), .RST(rst), .REQ_VALID(req_valid),
        .REQ_OP(req_op), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata),
        .REQ_READY(req_ready), .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata),
        .MEM_ADDR(mem_addr), .WRITE_VALUE_BUS(wr_bus), .READ_VALUE_BUS(rd_bus),
        .CS_N(cs_n), .WE_N(we_n), .OE_N(oe_n), .CLR_N(clr_n));
    sram_dev_model sram_dev_model_inst (.a(mem_addr), .d(wr_bus), .q(rd_bus),
        .cs_n(cs_n), .we_n(we_n), .oe_n(oe_n), .clr_n(clr_n));
    initial forever #50 mclk = ~mclk;
    task chk(input logic [3:0] seen, input logic [3:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t ns read %h expected %h", $time, seen, exp);
        end
    endtask
    // One request; reads and clears wait for the response pulse
    task xfer(input logic [1:0] op, input logic [9:0] ad, input logic [3:0] d);
        integer n;
        @(posedge mclk);
        req_valid <= 1'b1;
        req_op <= op;
        req_addr <= ad;
        req_wdata <= d;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (req_ready !== 1'b1 && n < 40);
        req_valid <= 1'b0;
        if (op == 2'd1) ref_mem[ad] = d;
        if (op == 2'd2) foreach (ref_mem[k]) ref_mem[k] = 0;
        if (op != 2'd1) begin
            do begin
                @(posedge mclk);
                n++;
            end while (rsp_valid !== 1'b1 && n < 80);
            got = rsp_rdata;
        end
        // A stuck handshake ends the run at once, as a mismatch
        if (n >= 40 + 40 * (op != 2'd1)) begin
            err_total++;
            $display("[ERR] %0t ns handshake timed out", $time);
            end_of_test;
        end
    endtask
    task end_of_test;
        $display("compares %0d errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        err_total++;
        $display("[ERR] %0t ns watchdog expired", $time);
        end_of_test;
    end
    initial begin
        void'($urandom(24121));
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        // Array corners first, then random words back to back
        xfer(2'd1, 10'h000, 4'ha);
        xfer(2'd1, 10'h3ff, 4'h5);
        xfer(2'd0, 10'h000, 4'h0);
        chk(got, 4'ha);
        xfer(2'd3, 10'h3ff, 4'h0);
        chk(got, 4'h5);
        addr_q = '{10'h000, 10'h3ff};
        repeat (24) begin
            a = 10'($urandom);
            xfer(2'd1, a, 4'($urandom));
            addr_q.push_back(a);
        end
        foreach (addr_q[k]) begin
            xfer(k[0] ? 2'd3 : 2'd0, addr_q[k], 4'h0);
            chk(got, ref_mem[addr_q[k]][3:0]);
        end
        xfer(2'd2, 10'h155, 4'h0);
        foreach (addr_q[k]) begin
            xfer(2'd0, addr_q[k], 4'h0);
            chk(got, ref_mem[addr_q[k]][3:0]);
        end
        xfer(2'd1, 10'h2aa, 4'hc);
        xfer(2'd0, 10'h2aa, 4'h0);
        chk(got, 4'hc);
        end_of_test;
    end
endmodule // tb_sram_host
